// ---- common/p1gp_pkg.sv ----
// Package holding register map, field positions and reset values of the port block
package p1gp_pkg;
    // ==========================================================
    // Geometry
    localparam int          P1GP_NPINS            = 8;
    localparam int          P1GP_AW               = 12;
    // ==========================================================
    // Register byte offsets
    localparam logic [11:0] P1GP_OFF_DATA         = 12'h000;
    localparam logic [11:0] P1GP_OFF_DIR          = 12'h004;
    localparam logic [11:0] P1GP_OFF_PULL         = 12'h008;
    localparam logic [11:0] P1GP_OFF_CTRL         = 12'h00C;
    localparam logic [11:0] P1GP_OFF_STAT         = 12'h010;
    // ==========================================================
    // Control register fields
    localparam int          P1GP_CTRL_SEG_LO      = 0;  // Segment select for pins 6 and 5
    localparam int          P1GP_CTRL_INCTL       = 2;  // Port input control
    localparam int          P1GP_CTRL_FLOAT       = 3;  // Standby pin float
    localparam int          P1GP_CTRL_IRQ0        = 4;  // Wake input kept, pin 0
    localparam int          P1GP_CTRL_IRQ4        = 5;  // Wake input kept, pin 4
    localparam int          P1GP_CTRL_W           = 6;
    // ==========================================================
    // Status register fields
    localparam int          P1GP_STAT_FLOATED     = 0;
    // ==========================================================
    // Reset values
    localparam logic [7:0]  P1GP_RST_DATA         = 8'h00;
    localparam logic [7:0]  P1GP_RST_DIR          = 8'h00;
    localparam logic [7:0]  P1GP_RST_PULL         = 8'h00;
    localparam logic [5:0]  P1GP_RST_CTRL         = 6'h00;
    // Segment pins: bit 5 and bit 6 of the port
    localparam logic [7:0]  P1GP_SEG_PINS         = 8'h60;
    localparam logic [7:0]  P1GP_WAKE_PIN0        = 8'h01;
    localparam logic [7:0]  P1GP_WAKE_PIN4        = 8'h10;
endpackage

// ---- hdl/p1gp_pinmux.sv ----
// Combinational per-pin drive, pull-up and input-blocking selection
`timescale 1ns/1ps
module p1gp_pinmux #(
    parameter int          W         = 8,
    parameter logic [W-1:0] OD_PINS  = '0
) (
    input  wire logic [W-1:0] latch,
    input  wire logic [W-1:0] dir,
    input  wire logic [W-1:0] pull_en,
    input  wire logic [W-1:0] periph_oe,
    input  wire logic [W-1:0] periph_out,
    input  wire logic [W-1:0] seg_sel,
    input  wire logic [W-1:0] keep_in,
    input  wire logic         floated,
    input  wire logic [W-1:0] pin_level,
    output logic      [W-1:0] drv_out,
    output logic      [W-1:0] drv_oe,
    output logic      [W-1:0] pull_on,
    output logic      [W-1:0] in_path
);
    always_comb begin
        for (int i = 0; i < W; i++) begin
            // Peripheral output wins over port output; segment pins drive nothing here
            if (floated || seg_sel[i]) begin
                drv_oe[i]  = 1'b0;
                drv_out[i] = 1'b0;
            end else if (periph_oe[i]) begin
                drv_out[i] = periph_out[i];
                drv_oe[i]  = !(OD_PINS[i] && periph_out[i]);
            end else if (dir[i]) begin
                drv_out[i] = latch[i];
                drv_oe[i]  = !(OD_PINS[i] && latch[i]);
            end else begin
                drv_out[i] = 1'b0;
                drv_oe[i]  = 1'b0;
            end
            // Pull-up is dropped while the pin drives low
            pull_on[i] = pull_en[i] && !(drv_oe[i] && !drv_out[i]);
            // Blocked inputs read low to stop open-input leakage
            in_path[i] = (floated && !keep_in[i]) ? 1'b0 : pin_level[i];
        end
    end
endmodule // p1gp_pinmux

// ---- hdl/p1gp_port.sv ----
// Eight-pin port with data latch, direction, pull-up and APB register access
// Summary of operation
// - Direction bit 1 makes the pin an output driving its latch bit.
// - Data writes update the latch; output pins show the new value.
// - Reading data of an output pin returns the latch bit.
// - Direction bit 0 makes the pin an input with driver off.
// - Writes to input pins still update the latch, not driven.
// - Input pins read pin level; read-modify-write reads return the latch.
// - Peripheral output enable drives pin; reads see pin, RMW sees latch.
// - Pin level reaches peripheral inputs and normal data reads, except blocked inputs in floated standby.
// - Segment select 1 picks LCD segment, 0 port; input control then set.
// - Reset clears all direction bits so every pin starts as input.
// - Float bit with stop or watch forces every pin to high impedance.
// - In floated standby each internal input, except an enabled wake pin, is blocked and held low.
// - Pins 0 and 4 keep input when their wake interrupt is enabled.
// - Float bit 0 keeps pin states and output levels in standby.
// - Pull-up enable 1 connects the internal pull-up; 0 disconnects.
// - Pull-up is disconnected while the pin drives low.
// - Open-drain output pins with latch 1 are left at high impedance.
// - Register bit n controls pin n.
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module p1gp_port
    import p1gp_pkg::*;
#(
    parameter int             NPINS   = p1gp_pkg::P1GP_NPINS,
    parameter logic [7:0]     OD_PINS = 8'h00
) (
    input  wire logic                          mclk,
    input  wire logic                          nrst,
    // APB slave
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [p1gp_pkg::P1GP_AW-1:0]  paddr,
    input  wire logic [31:0]                   pwdata,
    input  wire logic                          prmw,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    // Standby request from the power controller
    input  wire logic                          standby_req,
    // Shared peripherals
    input  wire logic [7:0]                    periph_oe,
    input  wire logic [7:0]                    periph_out,
    output logic      [7:0]                    periph_in,
    output logic      [1:0]                    segment_select_bits,
    output logic                               port_input_control,
    // Pins
    input  wire logic [7:0]                    pin_in,
    output logic      [7:0]                    pin_out,
    output logic      [7:0]                    pin_oe,
    output logic      [7:0]                    pin_pullup
);
    import p1gp_pkg::*;

    // ==========================================================
    // Elaboration check
    if (NPINS != 8) begin : g_bad_width
        $error("p1gp_port supports exactly eight pins");
    end

    // ==========================================================
    // State
    typedef struct packed {
        logic [7:0]            port_data_latch;
        logic [7:0]            port_direction;
        logic [7:0]            port_pullup_enable;
        logic [P1GP_CTRL_W-1:0] ctrl;
        logic                  floated;
        logic [31:0]           rdata;
        logic                  ready;
        logic                  slverr;
        logic [7:0]            out;
        logic [7:0]            oe;
        logic [7:0]            pull;
        logic [7:0]            pin_to_periph;
    } p1gp_state_type;

    p1gp_state_type st_r;
    p1gp_state_type st_nxt;

    logic [7:0] pin_sync;
    logic [7:0] mux_out;
    logic [7:0] mux_oe;
    logic [7:0] mux_pull;
    logic [7:0] mux_in;
    logic [7:0] seg_vec;
    logic [7:0] keep_vec;
    logic       float_nxt;
    logic [4:0] reg_hit;

    // ==========================================================
    // Helpers
    // Data read: latch for output pins without peripheral output enable, or RMW; pin level otherwise
    function automatic logic [7:0] p1gp_data_read(input logic [7:0] latch,
                                                  input logic [7:0] dir,
                                                  input logic [7:0] oe_p,
                                                  input logic [7:0] lvl,
                                                  input logic       rmw);
        logic [7:0] r;
        r = '0;
        for (int i = 0; i < 8; i++) begin
            if (rmw) begin
                r[i] = latch[i];
            end else if (dir[i] && !oe_p[i]) begin
                r[i] = latch[i];
            end else begin
                r[i] = lvl[i];
            end
        end
        return r;
    endfunction

    // Register select, one-hot: 0 data, 1 direction, 2 pull-up, 3 control, 4 status
    function automatic logic [4:0] p1gp_decode(input logic [P1GP_AW-1:0] a);
        logic [4:0] s;
        s = 5'b00000;
        if (a == P1GP_OFF_DATA) begin
            s[0] = 1'b1;
        end else if (a == P1GP_OFF_DIR) begin
            s[1] = 1'b1;
        end else if (a == P1GP_OFF_PULL) begin
            s[2] = 1'b1;
        end else if (a == P1GP_OFF_CTRL) begin
            s[3] = 1'b1;
        end else if (a == P1GP_OFF_STAT) begin
            s[4] = 1'b1;
        end
        return s;
    endfunction

    // ==========================================================
    // Pin input synchroniser
    p1gp_sync #(
        .W        (8)
    ) u_sync (
        .mclk     (mclk),
        .nrst     (nrst),
        .async_in (pin_in),
        .sync_out (pin_sync)
    );

    // Segment select applies to pins 5 and 6 only
    assign seg_vec  = {1'b0, st_r.ctrl[P1GP_CTRL_SEG_LO+1], st_r.ctrl[P1GP_CTRL_SEG_LO],
                       5'b00000} & P1GP_SEG_PINS;
    // Wake pins with their interrupt enabled keep their input while floated
    assign keep_vec = (st_r.ctrl[P1GP_CTRL_IRQ0] ? P1GP_WAKE_PIN0 : 8'h00)
                    | (st_r.ctrl[P1GP_CTRL_IRQ4] ? P1GP_WAKE_PIN4 : 8'h00);
    // Floating only when enabled; otherwise standby changes nothing
    assign float_nxt = standby_req && st_r.ctrl[P1GP_CTRL_FLOAT];
    // One decode serves both the setup answer and the write commit
    assign reg_hit   = p1gp_decode(paddr);

    // ==========================================================
    // Per-pin drive selection
    p1gp_pinmux #(
        .W          (8),
        .OD_PINS    (OD_PINS)
    ) u_mux (
        .latch      (st_r.port_data_latch),
        .dir        (st_r.port_direction),
        .pull_en    (st_r.port_pullup_enable),
        .periph_oe  (periph_oe),
        .periph_out (periph_out),
        .seg_sel    (seg_vec),
        .keep_in    (keep_vec),
        .floated    (st_r.floated),
        .pin_level  (pin_sync),
        .drv_out    (mux_out),
        .drv_oe     (mux_oe),
        .pull_on    (mux_pull),
        .in_path    (mux_in)
    );

    // ==========================================================
    // Next-state logic: APB slave with zero wait states
    always_comb begin
        st_nxt         = st_r;
        st_nxt.ready   = 1'b0;
        st_nxt.slverr  = 1'b0;
        st_nxt.floated = float_nxt;
        // Registered pin outputs keep every top output straight from a flop
        st_nxt.out           = mux_out;
        st_nxt.oe            = mux_oe;
        st_nxt.pull          = mux_pull;
        st_nxt.pin_to_periph = mux_in;
        // Setup phase seen: answer in the access phase, read data captured now
        if (psel && !penable) begin
            st_nxt.ready  = 1'b1;
            st_nxt.slverr = (reg_hit == 5'b00000);         // Unmapped: error, no change
            st_nxt.rdata  = '0;
            if (!pwrite) begin
                if (reg_hit[0]) begin
                    st_nxt.rdata[7:0] = p1gp_data_read(st_r.port_data_latch,
                                                       st_r.port_direction,
                                                       periph_oe, mux_in, prmw);
                end else if (reg_hit[1]) begin
                    st_nxt.rdata[7:0] = st_r.port_direction;
                end else if (reg_hit[2]) begin
                    st_nxt.rdata[7:0] = st_r.port_pullup_enable;
                end else if (reg_hit[3]) begin
                    st_nxt.rdata[P1GP_CTRL_W-1:0] = st_r.ctrl;
                end else if (reg_hit[4]) begin
                    st_nxt.rdata[P1GP_STAT_FLOATED] = st_r.floated;
                end
            end
        end
        // Writes land only at the edge where pready is seen high, so an
        // abandoned setup changes nothing; status is read-only
        if (psel && penable && pwrite && st_r.ready) begin
            if (reg_hit[0]) begin
                st_nxt.port_data_latch = pwdata[7:0];
            end else if (reg_hit[1]) begin
                st_nxt.port_direction = pwdata[7:0];
            end else if (reg_hit[2]) begin
                st_nxt.port_pullup_enable = pwdata[7:0];
            end else if (reg_hit[3]) begin
                st_nxt.ctrl = pwdata[P1GP_CTRL_W-1:0];
            end
        end
    end

    // ==========================================================
    // Registers; direction clears to all-input on reset
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_r                    <= '0;
            st_r.port_data_latch    <= P1GP_RST_DATA;
            st_r.port_direction     <= P1GP_RST_DIR;
            st_r.port_pullup_enable <= P1GP_RST_PULL;
            st_r.ctrl               <= P1GP_RST_CTRL;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // Outputs
    assign prdata              = st_r.rdata;
    assign pready              = st_r.ready;
    assign pslverr             = st_r.slverr;
    assign pin_out             = st_r.out;
    assign pin_oe              = st_r.oe;
    assign pin_pullup          = st_r.pull;
    assign periph_in           = st_r.pin_to_periph;
    assign segment_select_bits = st_r.ctrl[P1GP_CTRL_SEG_LO +: 2];
    assign port_input_control  = st_r.ctrl[P1GP_CTRL_INCTL];
endmodule // p1gp_port

// ---- hdl/p1gp_sync.sv ----
// Two-flop synchroniser for the pin input vector
`timescale 1ns/1ps
module p1gp_sync #(
    parameter int W = 8
) (
    input  wire logic         mclk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } p1gp_sync_type;
    p1gp_sync_type st_r;
    p1gp_sync_type st_nxt;

    // ==========================================================
    // First stage feeds only the second
    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = async_in;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sync_out = st_r.s2;
endmodule // p1gp_sync

// ---- tb/p1gp_pins_model.sv ----
// Board-side model of the eight port pins: outside drivers, pull-ups, floating lines
`timescale 1ns/1ps
module p1gp_pins_model (
    input  wire logic       mclk,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] pin_pullup,
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    output logic      [7:0] pin_lvl
);
    logic [7:0] wobble_r = 8'h00;
    // Undriven lines wander so a stale value never looks valid
    always @(posedge mclk) wobble_r <= ~wobble_r;
    // Port driver first, then outside driver, then pull-up
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe[i]) pin_lvl[i] = pin_out[i];
            else if (ext_en[i]) pin_lvl[i] = ext_val[i];
            else if (pin_pullup[i]) pin_lvl[i] = 1'b1;
            else pin_lvl[i] = wobble_r[i];
        end
    end
endmodule // p1gp_pins_model

// ---- tb/p1gp_port_chk.sv ----
// Concurrent checks on the port block, bound to its top module
`timescale 1ns/1ps
module p1gp_port_chk
    import p1gp_pkg::*;
#(
    parameter logic [7:0] OD_PINS = 8'h00
) (
    input wire logic                         mclk,
    input wire logic                         nrst,
    input wire logic                         psel,
    input wire logic                         penable,
    input wire logic [p1gp_pkg::P1GP_AW-1:0] paddr,
    input wire logic [31:0]                  prdata,
    input wire logic                         pready,
    input wire logic                         pslverr,
    input wire logic                         standby_req,
    input wire logic [7:0]                   pin_in,
    input wire logic [7:0]                   periph_in,
    input wire logic [1:0]                   segment_select_bits,
    input wire logic [7:0]                   pin_out,
    input wire logic [7:0]                   pin_oe,
    input wire logic [7:0]                   pin_pullup
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    logic mapped;
    // ==========================================================
    // Decode of the five word offsets
    assign mapped = paddr inside {P1GP_OFF_DATA, P1GP_OFF_DIR, P1GP_OFF_PULL, P1GP_OFF_CTRL,
                                  P1GP_OFF_STAT};
    sequence s_setup;
        psel && !penable;
    endsequence
    // Sync depth is three edges, five leaves margin
    sequence s_calm_in;
        (!standby_req && $stable(pin_in))[*5];
    endsequence
    a_ok_decode: assert property (s_setup ##0 mapped |=> pready && !pslverr)
        else $error("mapped access not answered cleanly");
    a_err_decode: assert property (s_setup ##0 !mapped |=> pready && pslverr)
        else $error("unmapped access not refused");
    a_ready_cause: assert property (pready |-> psel && penable && $past(psel && !penable))
        else $error("ready without a setup cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held beyond one cycle");
    a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    a_reset_inputs: assert property ($rose(nrst) |-> pin_oe == 8'h00)
        else $error("pin driven straight after reset");
    a_pull_low: assert property ((pin_pullup & pin_oe & ~pin_out) == 8'h00)
        else $error("pull-up on while driving low");
    a_od_high: assert property ((pin_oe & pin_out & OD_PINS) == 8'h00)
        else $error("open-drain pin driven high");
    a_seg_off: assert property ((segment_select_bits == 2'b11)[*3]
        |-> (pin_oe & P1GP_SEG_PINS) == 8'h00)
        else $error("segment pin still driven by port");
    a_in_route: assert property (s_calm_in |-> periph_in == pin_in)
        else $error("pin level not routed to peripherals");
endmodule // p1gp_port_chk

bind p1gp_port p1gp_port_chk #(.OD_PINS(OD_PINS)) i_p1gp_port_chk (.mclk, .nrst, .psel,
    .penable, .paddr, .prdata, .pready, .pslverr, .standby_req, .pin_in, .periph_in,
    .segment_select_bits, .pin_out, .pin_oe, .pin_pullup);

// ---- tb/tb_top.sv ----
// Self-checking bench for the eight-pin port block
`timescale 1ns/1ps
module tb_top;
    import p1gp_pkg::*;
    localparam logic [7:0] OD = 8'h80;
    logic        mclk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        prmw = 1'b0, standby_req = 1'b0, pready, pslverr, port_input_control;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [7:0]  periph_oe = 8'h00, periph_out = 8'h00, ext_en = 8'h00, ext_val = 8'h00;
    logic [7:0]  periph_in, lvl, pin_out, pin_oe, pin_pullup;
    logic [1:0]  segment_select_bits;
    logic [33:0] q[$], nt;
    int          fails = 0, n_tests = 0, cyc = 0;
    always #5 mclk = ~mclk;
    p1gp_port #(.OD_PINS(OD)) i_p1gp_port (.mclk, .nrst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prmw, .prdata, .pready, .pslverr, .standby_req, .periph_oe, .periph_out,
        .periph_in, .segment_select_bits, .port_input_control, .pin_in(lvl), .pin_out, .pin_oe,
        .pin_pullup);
    p1gp_pins_model i_p1gp_pins_model (.mclk, .pin_out, .pin_oe, .pin_pullup, .ext_en, .ext_val,
        .pin_lvl(lvl));
    // ==========================================================
    // Compare, verdict and one APB transfer
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        if (fails == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Idle edge first, so psel is never set twice in one step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic r, input logic e, input logic [31:0] x);
        @(posedge mclk);
        q.push_back({w, e, x});
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        prmw <= r;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Answer monitor against the oldest note; cycle ceiling against hangs
    always @(posedge mclk) begin
        if (pready === 1'b1 && q.size() > 0) begin
            nt = q.pop_front();
            chk(32'(pslverr), 32'(nt[32]));
            if (!nt[33]) chk(prdata, nt[31:0]);
        end
        cyc++;
        if (cyc == 4000) begin
            fails++;
            end_of_test();
        end
    end
    initial begin
        logic [7:0] d, m, v, po, pv, p, oe, out, lv;
        void'($urandom(89));
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        apb(0, P1GP_OFF_DIR, 32'h0, 0, 0, 32'h0);
        apb(0, P1GP_OFF_PULL, 32'h0, 0, 0, 32'h0);
        chk(32'(pin_oe), 32'h0);
        // Random mixes of output, input and peripheral-driven pins
        for (int k = 0; k < 6; k++) begin
            d = 8'($urandom);
            m = 8'($urandom);
            v = 8'($urandom);
            p = 8'($urandom);
            pv = 8'($urandom);
            po = 8'($urandom) & ~m & ~OD;
            oe = (m & ~(OD & d)) | po;
            out = (m & d) | (po & pv);
            lv = (oe & out) | (~oe & v);
            periph_oe <= po;
            periph_out <= pv;
            ext_en <= ~oe;
            ext_val <= v;
            apb(1, P1GP_OFF_DATA, 32'(d), 0, 0, 32'h0);
            apb(1, P1GP_OFF_DIR, 32'(m), 0, 0, 32'h0);
            apb(1, P1GP_OFF_PULL, 32'(p), 0, 0, 32'h0);
            repeat (4) @(posedge mclk);
            chk(32'(pin_oe), 32'(oe));
            chk(32'(pin_out & pin_oe), 32'(out & oe));
            chk(32'(pin_pullup), 32'(p & ~(oe & ~out)));
            chk(32'(periph_in), 32'(lv));
            apb(0, P1GP_OFF_DATA, 32'h0, 0, 0, 32'((m & d) | (~m & lv)));
            apb(0, P1GP_OFF_DATA, 32'h0, 1, 0, 32'(d));
        end
        // Segment select on pins 5 and 6, then standby kept and floated
        periph_oe <= 8'h00;
        ext_en <= 8'h60;
        ext_val <= 8'hFF;
        apb(1, P1GP_OFF_DATA, 32'h0, 0, 0, 32'h0);
        apb(1, P1GP_OFF_DIR, 32'hFF, 0, 0, 32'h0);
        apb(1, P1GP_OFF_CTRL, 32'h07, 0, 0, 32'h0);
        apb(0, P1GP_OFF_CTRL, 32'h0, 0, 0, 32'h07);
        standby_req <= 1'b1;
        repeat (4) @(posedge mclk);
        chk(32'(segment_select_bits), 32'h3);
        chk(32'(port_input_control), 32'h1);
        chk(32'(pin_oe), 32'h9F);
        for (int k = 0; k < 2; k++) begin
            standby_req <= 1'b0;
            apb(1, P1GP_OFF_CTRL, (k == 0) ? 32'h1F : 32'h2F, 0, 0, 32'h0);
            ext_en <= 8'hFF;
            standby_req <= 1'b1;
            // Float, driver off, two sync stages and the routing flop: five edges, six waited
            repeat (6) @(posedge mclk);
            chk(32'(pin_oe), 32'h0);
            chk(32'(periph_in), (k == 0) ? 32'h01 : 32'h10);
            apb(1, P1GP_OFF_STAT, 32'h0, 0, 0, 32'h0);
            apb(0, P1GP_OFF_STAT, 32'h0, 0, 0, 32'h1);
        end
        apb(0, 12'h014, 32'h0, 0, 1, 32'h0);
        repeat (2) @(posedge mclk);
        end_of_test();
    end
endmodule // tb_top
